/* File: tcp_pkg.sv */
`default_nettype none

package tcp_pkg;

    // Three-state strap level as resolved by the pad sense circuit.
    typedef enum logic [1:0] {
        STRAP_LOW,
        STRAP_FLOAT,
        STRAP_HIGH
    } tcp_strap_t;

    // Termination seen on one configuration channel line.
    typedef enum logic [1:0] {
        CC_OPEN,
        CC_RA,
        CC_RD,
        CC_RP
    } tcp_cc_t;

    // Current level, either detected as sink or advertised as source.
    typedef enum logic [1:0] {
        CUR_DEFAULT,
        CUR_1A5,
        CUR_3A0
    } tcp_cur_t;

    // Port role chosen by the role strap.
    typedef enum logic [1:0] {
        ROLE_SNK,
        ROLE_DRP,
        ROLE_SRC
    } tcp_role_t;

    // Enable and sampling sequence.
    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_SETTLE,
        SEQ_RUN
    } tcp_seq_t;

    // Serial bus addresses, write form with the direction bit at zero.
    localparam logic [7:0] I2C_ADDR_STRAP_HIGH = 8'h62;
    localparam logic [7:0] I2C_ADDR_STRAP_LOW  = 8'h42;

    // Two-bit orientation status codes.
    localparam logic [1:0] FLIP_NONE = 2'h0;
    localparam logic [1:0] FLIP_CC1  = 2'h1;
    localparam logic [1:0] FLIP_CC2  = 2'h2;

    // Reset values of latched configuration and status.
    localparam tcp_strap_t STRAP_RESET_CODE = STRAP_FLOAT;
    localparam tcp_role_t  ROLE_RESET       = ROLE_DRP;
    localparam tcp_cur_t   CUR_RESET        = CUR_DEFAULT;

    // Time the strap pins stay released before they are sampled.
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned STRAP_SETTLE_NS   = 200;
    localparam int unsigned STRAP_SETTLE_CYC  =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // A sink looks for Rp, a source looks for Rd; Ra counts as open.
    function automatic logic cc_seen(input tcp_cc_t cc,
                                     input logic    as_source);
        cc_seen = as_source ? (cc == CC_RD) : (cc == CC_RP);
    endfunction : cc_seen

endpackage : tcp_pkg

`default_nettype wire

/* File: tcp_strap_latch.sv */
`default_nettype none

// Holds one sampled strap level until the next sample strobe.
module tcp_strap_latch
    import tcp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Sample strobe and pad level
    input  wire logic       sample,
    input  wire tcp_strap_t level,
    // Latched level
    output var  tcp_strap_t code
);

    tcp_strap_t next_code;

    // Later pin activity cannot disturb the held level.
    always_comb begin
        next_code = sample ? level : code;
    end

    // Register the held level.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code <= STRAP_RESET_CODE;
        end else begin
            code <= next_code;
        end
    end

endmodule : tcp_strap_latch

`default_nettype wire

/* File: tcp_pin_mode_ctrl.sv */
`default_nettype none

// Operation
// - I2C mode: shared pin is open-drain interrupt
// - GPIO mode: shared pin low on audio accessory
// - I2C mode: current pins carry SDA and SCL
// - GPIO sink: drive current pins from detected level
// - Sample straps on enable fall or soft reset
// - Role strap: high source, float dual, low sink
// - Role strap pin then shows debug flag
// - Address strap: high 62h, float GPIO, low 42h
// - Address strap pin then shows orientation
// - Attached role pin low as source only
// - Enable input is active low
// - Orientation bits decoded from CC terminations
// - Sink debug partner still yields orientation
// - Source debug partner still yields orientation
// - Debug partner flagged when both lines see it
module tcp_pin_mode_ctrl
    import tcp_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = STRAP_SETTLE_CYC
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Enable and soft reset command
    input  wire logic       en_n,
    input  wire logic       soft_reset_cmd,
    // Role strap pin, then debug flag output
    input  wire tcp_strap_t role_strap_level,
    output logic            role_strap_dbg_out,
    output logic            role_strap_dbg_oe,
    // Address strap pin, then orientation output
    input  wire tcp_strap_t addr_strap_level,
    output logic            addr_strap_flip_pin_out,
    output logic            addr_strap_flip_pin_oe,
    // Open-drain attached role pin
    output logic            attached_role_out_out,
    output logic            attached_role_out_oe,
    // Open-drain interrupt or audio flag pin
    output logic            irq_or_audio_flag_pin_out,
    output logic            irq_or_audio_flag_pin_oe,
    // Shared data pin, or current bit a
    input  wire logic       serial_data_or_current_bit_a_in,
    output logic            serial_data_or_current_bit_a_out,
    output logic            serial_data_or_current_bit_a_oe,
    // Shared clock pin, or current bit b
    input  wire logic       serial_clock_or_current_bit_b_in,
    output logic            serial_clock_or_current_bit_b_out,
    output logic            serial_clock_or_current_bit_b_oe,
    // Attach state from the detection logic
    input  wire logic       attached_src,
    input  wire logic       attached_snk,
    input  wire tcp_cc_t    cc1_state,
    input  wire tcp_cc_t    cc2_state,
    input  wire logic       dbg_cc2_sel,
    input  wire logic       audio_det,
    input  wire tcp_cur_t   snk_cur_level,
    // Serial slave side
    input  wire logic       irq_req,
    input  wire logic       i2c_sda_pull,
    input  wire logic       i2c_scl_pull,
    output logic            i2c_sda_rx,
    output logic            i2c_scl_rx,
    // Configuration and status
    output logic            dev_active,
    output tcp_role_t       port_role,
    output logic            i2c_mode,
    output logic [7:0]      i2c_addr,
    output logic [1:0]      flip_state_bits,
    output logic            debug_test_partner,
    output tcp_cur_t        adv_cur_level,
    output logic            adv_cur_reserved
);

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

    // Refuse a settle time the counter cannot represent.
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4096) begin : g_bad_settle
        $error("SETTLE_CYCLES must lie between 1 and 4096.");
    end

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

    tcp_seq_t         state, next_state;
    logic [CNT_W-1:0] settle_cnt, next_settle_cnt;
    logic             en_n_q, next_en_n_q, sample_now, enable_fall;

    // The enable history resets high, so an enable already low when
    // reset releases counts as a falling edge: this covers power-up.
    assign enable_fall = en_n_q & ~en_n;

    // Straps are released during the settle window so the pad sense
    // sees the board strap rather than our own drive.
    always_comb begin
        next_state      = state;
        next_settle_cnt = settle_cnt;
        next_en_n_q     = en_n;
        sample_now      = 1'b0;
        if (en_n) begin
            next_state      = SEQ_OFF;
            next_settle_cnt = '0;
        end else begin
            case (state)
                SEQ_OFF: begin
                    if (enable_fall) begin
                        next_state      = SEQ_SETTLE;
                        next_settle_cnt = '0;
                    end
                end
                SEQ_SETTLE: begin
                    if (settle_cnt == SETTLE_LAST) begin
                        sample_now = 1'b1;
                        next_state = SEQ_RUN;
                    end else begin
                        next_settle_cnt = settle_cnt + 1'b1;
                    end
                end
                SEQ_RUN: begin
                    if (soft_reset_cmd) begin
                        next_state      = SEQ_SETTLE;
                        next_settle_cnt = '0;
                    end
                end
                default: begin
                    next_state = SEQ_OFF;
                end
            endcase
        end
    end

    // Register the sequence.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= SEQ_OFF;
            settle_cnt <= '0;
            en_n_q     <= 1'b1;
        end else begin
            state      <= next_state;
            settle_cnt <= next_settle_cnt;
            en_n_q     <= next_en_n_q;
        end
    end

    tcp_strap_t role_code, mode_code;

    tcp_strap_latch u_role_latch (
        .clk    (clk),
        .rst    (rst),
        .sample (sample_now),
        .level  (role_strap_level),
        .code   (role_code)
    );

    tcp_strap_latch u_mode_latch (
        .clk    (clk),
        .rst    (rst),
        .sample (sample_now),
        .level  (addr_strap_level),
        .code   (mode_code)
    );

    tcp_role_t  next_port_role;
    logic       next_i2c_mode;
    logic [7:0] next_i2c_addr;
    logic       next_dev_active;

    // Decode the held strap codes.
    always_comb begin
        case (role_code)
            STRAP_HIGH: next_port_role = ROLE_SRC;
            STRAP_LOW:  next_port_role = ROLE_SNK;
            default:    next_port_role = ROLE_DRP;
        endcase
        case (mode_code)
            STRAP_HIGH: begin
                next_i2c_mode = 1'b1;
                next_i2c_addr = I2C_ADDR_STRAP_HIGH;
            end
            STRAP_LOW: begin
                next_i2c_mode = 1'b1;
                next_i2c_addr = I2C_ADDR_STRAP_LOW;
            end
            default: begin
                next_i2c_mode = 1'b0;
                next_i2c_addr = 8'h00;
            end
        endcase
        next_dev_active = (next_state == SEQ_RUN);
    end

    // Register the configuration.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_role  <= ROLE_RESET;
            i2c_mode   <= 1'b0;
            i2c_addr   <= 8'h00;
            dev_active <= 1'b0;
        end else begin
            port_role  <= next_port_role;
            i2c_mode   <= next_i2c_mode;
            i2c_addr   <= next_i2c_addr;
            dev_active <= next_dev_active;
        end
    end

    logic       seen1, seen2, attached, run, gpio_run, od_low;
    logic [1:0] next_flip;
    logic       next_dbg, next_role_oe, next_flip_oe, next_id_oe;
    logic       next_irq_oe, next_a_oe, next_b_oe, next_sda_rx, next_scl_rx;
    tcp_cur_t   next_adv;
    logic       next_adv_rsv;

    // Source attachment takes priority if both reports are ever high.
    assign seen1    = cc_seen(cc1_state, attached_src);
    assign seen2    = cc_seen(cc2_state, attached_src);
    assign attached = attached_src | attached_snk;
    assign run      = (next_state == SEQ_RUN); // Same as next_dev_active; leads dev_active by one cycle.
    assign gpio_run = run & ~i2c_mode;

    // Status next values and pin enables; all pins float when idle.
    always_comb begin
        next_flip    = FLIP_NONE;
        next_dbg     = 1'b0;
        next_a_oe    = 1'b0;
        next_b_oe    = 1'b0;
        next_sda_rx  = 1'b1;
        next_scl_rx  = 1'b1;
        next_adv     = adv_cur_level;
        next_adv_rsv = adv_cur_reserved;
        if (attached) begin
            if (seen1 && seen2) begin
                // Both lines terminated: a debug partner, whose
                // orientation is resolved by the detection logic.
                next_dbg  = 1'b1;
                next_flip = dbg_cc2_sel ? FLIP_CC2
                                        : FLIP_CC1;
            end else if (seen2) begin
                next_flip = FLIP_CC2;
            end else if (seen1) begin
                next_flip = FLIP_CC1;
            end
        end
        next_role_oe = run;
        next_flip_oe = run;
        next_id_oe   = run & attached_src;
        if (i2c_mode) begin
            next_irq_oe = run & irq_req;
        end else begin
            next_irq_oe = run & audio_det;
        end
        if (run && i2c_mode) begin
            // Slave pulls low through the pad; the bus level returns.
            next_a_oe   = i2c_sda_pull;
            next_b_oe   = i2c_scl_pull;
            next_sda_rx = serial_data_or_current_bit_a_in;
            next_scl_rx = serial_clock_or_current_bit_b_in;
        end
        if (gpio_run && attached_snk && !attached_src) begin
            next_a_oe = (snk_cur_level != CUR_DEFAULT);
            next_b_oe = (snk_cur_level == CUR_3A0);
        end
        if (gpio_run && attached_src) begin
            // Reserved pattern keeps the last good level and flags it.
            case ({serial_data_or_current_bit_a_in,
                   serial_clock_or_current_bit_b_in})
                2'h3: begin
                    next_adv     = CUR_DEFAULT;
                    next_adv_rsv = 1'b0;
                end
                2'h1: begin
                    next_adv     = CUR_1A5;
                    next_adv_rsv = 1'b0;
                end
                2'h0: begin
                    next_adv     = CUR_3A0;
                    next_adv_rsv = 1'b0;
                end
                default: begin
                    next_adv_rsv = 1'b1;
                end
            endcase
        end else if (!gpio_run) begin
            next_adv     = CUR_RESET;
            next_adv_rsv = 1'b0;
        end
    end

    // Register status and every pin drive.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flip_state_bits                  <= FLIP_NONE;
            debug_test_partner               <= 1'b0;
            role_strap_dbg_out               <= 1'b1;
            role_strap_dbg_oe                <= 1'b0;
            addr_strap_flip_pin_out          <= 1'b0;
            addr_strap_flip_pin_oe           <= 1'b0;
            attached_role_out_oe             <= 1'b0;
            irq_or_audio_flag_pin_oe         <= 1'b0;
            serial_data_or_current_bit_a_oe  <= 1'b0;
            serial_clock_or_current_bit_b_oe <= 1'b0;
            i2c_sda_rx                       <= 1'b1;
            i2c_scl_rx                       <= 1'b1;
            adv_cur_level                    <= CUR_RESET;
            adv_cur_reserved                 <= 1'b0;
            od_low                           <= 1'b0;
        end else begin
            flip_state_bits                  <= next_flip;
            debug_test_partner               <= next_dbg;
            role_strap_dbg_out               <= ~next_dbg;
            role_strap_dbg_oe                <= next_role_oe;
            addr_strap_flip_pin_out          <= next_flip[1];
            addr_strap_flip_pin_oe           <= next_flip_oe;
            attached_role_out_oe             <= next_id_oe;
            irq_or_audio_flag_pin_oe         <= next_irq_oe;
            serial_data_or_current_bit_a_oe  <= next_a_oe;
            serial_clock_or_current_bit_b_oe <= next_b_oe;
            i2c_sda_rx                       <= next_sda_rx;
            i2c_scl_rx                       <= next_scl_rx;
            adv_cur_level                    <= next_adv;
            adv_cur_reserved                 <= next_adv_rsv;
            od_low                           <= 1'b0;
        end
    end

    // Open-drain pins only ever pull low; the enable does the work.
    assign attached_role_out_out             = od_low;
    assign irq_or_audio_flag_pin_out         = od_low;
    assign serial_data_or_current_bit_a_out  = od_low;
    assign serial_clock_or_current_bit_b_out = od_low;

endmodule : tcp_pin_mode_ctrl

`default_nettype wire

/* File: tcp_pin_mode_checker.sv */
`default_nettype none

// Watches the pin outputs against enable, attach and mode inputs.
module tcp_pin_mode_checker
    import tcp_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = STRAP_SETTLE_CYC
)
(
    // Clock, reset and stimulus
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       en_n,
    input wire logic       attached_src,
    input wire logic       attached_snk,
    input wire logic       audio_det,
    input wire logic       irq_req,
    input wire tcp_cur_t   snk_cur_level,
    // Pin drive
    input wire logic       role_strap_dbg_out,
    input wire logic       role_strap_dbg_oe,
    input wire logic       addr_strap_flip_pin_out,
    input wire logic       addr_strap_flip_pin_oe,
    input wire logic       attached_role_out_oe,
    input wire logic       irq_or_audio_flag_pin_oe,
    input wire logic       serial_data_or_current_bit_a_oe,
    input wire logic       serial_clock_or_current_bit_b_oe,
    // Status
    input wire logic       dev_active,
    input wire tcp_role_t  port_role,
    input wire logic       i2c_mode,
    input wire logic [7:0] i2c_addr,
    input wire logic [1:0] flip_state_bits,
    input wire logic       debug_test_partner
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SET_N = SETTLE_CYCLES;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Enable taken and kept low; the orientation pin stays released for the settle time.
    sequence s_wake;
        $fell(en_n) ##1 !en_n;
    endsequence
    sequence s_settled;
        (!dev_active && !addr_strap_flip_pin_oe) ##[SET_N:SET_N]
        (dev_active && addr_strap_flip_pin_oe);
    endsequence
    // Running long enough that the decode has landed.
    sequence s_running;
        dev_active && $past(dev_active) && $past(dev_active, 2);
    endsequence

    // Mode is checked stable so the one-cycle mode handover is skipped.
    a_irq_gpio_audio: assert property (
        dev_active && !i2c_mode && $stable(i2c_mode)
        |-> irq_or_audio_flag_pin_oe == $past(audio_det))
        else $error("audio pin wrong");
    a_irq_i2c_req: assert property (
        dev_active && i2c_mode && $stable(i2c_mode)
        |-> irq_or_audio_flag_pin_oe == $past(irq_req))
        else $error("irq pin wrong");
    a_role_pin_src: assert property (
        attached_role_out_oe == (dev_active && $past(attached_src)))
        else $error("attached role pin wrong");
    a_flip_pin_map: assert property (
        addr_strap_flip_pin_oe
        |-> addr_strap_flip_pin_out == flip_state_bits[1])
        else $error("flip pin wrong");
    a_dbg_pin_map: assert property (
        role_strap_dbg_oe |-> role_strap_dbg_out == !debug_test_partner)
        else $error("debug pin wrong");
    a_settle_window: assert property (s_wake |-> s_settled)
        else $error("settle timing wrong");
    a_config_hold: assert property (
        s_running |-> $stable(port_role) && $stable(i2c_mode)
        && $stable(i2c_addr))
        else $error("config changed");
    a_gpio_sink_cur: assert property (
        dev_active && !i2c_mode && $stable(i2c_mode)
        && $past(attached_snk) && !$past(attached_src)
        |-> serial_data_or_current_bit_a_oe
            == ($past(snk_cur_level) != CUR_DEFAULT)
        && serial_clock_or_current_bit_b_oe
            == ($past(snk_cur_level) == CUR_3A0))
        else $error("sink current pins wrong");
endmodule : tcp_pin_mode_checker

bind tcp_pin_mode_ctrl tcp_pin_mode_checker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) i_chk (.*);

`default_nettype wire

/* File: tcp_cc_partner.sv */
`default_nettype none

// Far-end port partner: line terminations and the external current straps.
module tcp_cc_partner
    import tcp_pkg::*;
(
    // Partner kind and plug state
    input  wire logic       is_src,
    input  wire logic       present,
    input  wire logic       flip,
    input  wire logic       both,
    input  wire logic       ra,
    output tcp_cc_t         cc1,
    output tcp_cc_t         cc2,
    // Current straps; a zero bit pulls its pin low
    input  wire logic       drive_en,
    input  wire logic [1:0] cur_pat,
    output logic            a_low,
    output logic            b_low
);
    timeunit 1ns;
    timeprecision 1ps;

    tcp_cc_t term;

    // A source partner shows Rp and a sink Rd; the idle line may carry Ra.
    always_comb begin
        term = is_src ? CC_RP : CC_RD;
        cc1 = CC_OPEN;
        cc2 = CC_OPEN;
        if (present) begin
            cc1 = (flip && !both) ? (ra ? CC_RA : CC_OPEN) : term;
            cc2 = (!flip && !both) ? (ra ? CC_RA : CC_OPEN) : term;
        end
    end

    // Released straps fall back to the pull-up, never to a stale level.
    assign a_low = drive_en && !cur_pat[1];
    assign b_low = drive_en && !cur_pat[0];
endmodule : tcp_cc_partner

`default_nettype wire

/* File: typec_pin_mode_status_outputs_tb.sv */
`default_nettype none

module typec_pin_mode_status_outputs_tb
    import tcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Device inputs; enable is already low so release counts as power-up.
    logic       clk = 1'b0, rst = 1'b1, en_n = 1'b0, soft_reset_cmd = 1'b0;
    tcp_strap_t role_strap_level = STRAP_HIGH, addr_strap_level = STRAP_HIGH;
    logic       attached_src = 1'b0, attached_snk = 1'b0, dbg_cc2_sel = 1'b0;
    logic       audio_det = 1'b0, irq_req = 1'b0;
    logic       i2c_sda_pull = 1'b0, i2c_scl_pull = 1'b0;
    tcp_cur_t   snk_cur_level = CUR_DEFAULT;
    tcp_cc_t    cc1_state, cc2_state;
    // Partner controls and wire levels.
    logic       p_src = 1'b0, p_on = 1'b0, p_both = 1'b0, p_ra = 1'b0;
    logic       p_drv = 1'b0;
    logic [1:0] p_pat = 2'h3;
    logic       a_low, b_low, sda_lvl, scl_lvl;
    // Device outputs.
    logic       role_strap_dbg_out, role_strap_dbg_oe, attached_role_out_oe;
    logic       addr_strap_flip_pin_out, addr_strap_flip_pin_oe;
    logic       irq_or_audio_flag_pin_oe, sda_out, sda_oe, scl_out, scl_oe;
    logic       i2c_sda_rx, i2c_scl_rx, dev_active, i2c_mode;
    logic       debug_test_partner, adv_cur_reserved;
    logic [7:0] i2c_addr;
    logic [1:0] flip_state_bits;
    tcp_role_t  port_role;
    tcp_cur_t   adv_cur_level;
    int         bad_count = 0, checks_done = 0;

    always #5 clk = !clk;

    tcp_pin_mode_ctrl #(.SETTLE_CYCLES(2)) i_dut (
        .clk, .rst, .en_n, .soft_reset_cmd, .role_strap_level,
        .role_strap_dbg_out, .role_strap_dbg_oe, .addr_strap_level,
        .addr_strap_flip_pin_out, .addr_strap_flip_pin_oe,
        .attached_role_out_out(), .attached_role_out_oe,
        .irq_or_audio_flag_pin_out(), .irq_or_audio_flag_pin_oe,
        .serial_data_or_current_bit_a_in(sda_lvl),
        .serial_data_or_current_bit_a_out(sda_out),
        .serial_data_or_current_bit_a_oe(sda_oe),
        .serial_clock_or_current_bit_b_in(scl_lvl),
        .serial_clock_or_current_bit_b_out(scl_out),
        .serial_clock_or_current_bit_b_oe(scl_oe),
        .attached_src, .attached_snk, .cc1_state, .cc2_state, .dbg_cc2_sel,
        .audio_det, .snk_cur_level, .irq_req, .i2c_sda_pull, .i2c_scl_pull,
        .i2c_sda_rx, .i2c_scl_rx, .dev_active, .port_role, .i2c_mode,
        .i2c_addr, .flip_state_bits, .debug_test_partner, .adv_cur_level,
        .adv_cur_reserved
    );

    tcp_cc_partner i_partner (
        .is_src(p_src), .present(p_on), .flip(dbg_cc2_sel), .both(p_both),
        .ra(p_ra), .cc1(cc1_state), .cc2(cc2_state), .drive_en(p_drv),
        .cur_pat(p_pat), .a_low, .b_low
    );

    // Open-drain wires with pull-ups; either party may pull them low.
    assign sda_lvl = !((sda_oe && !sda_out) || a_low);
    assign scl_lvl = !((scl_oe && !scl_out) || b_low);

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // Way 0 waits out power-up, 1 toggles enable, 2 issues a soft reset.
    task automatic t_en(input tcp_strap_t r, a, input int way);
        int i;
        role_strap_level = r;
        addr_strap_level = a;
        if (way == 1) begin
            en_n = 1'b1;
            step(1);
            en_n = 1'b0;
        end
        if (way == 2) soft_reset_cmd = 1'b1;
        step(1);
        soft_reset_cmd = 1'b0;
        step(1);
        for (i = 0; i < 64 && dev_active !== 1'b1; i++) step(1);
        if (i == 64) begin
            bad_count++;
            wrap_up();
        end
        step(1);
    endtask : t_en

    // Each strap level through its own sampling cause; later levels ignored.
    task automatic t_straps;
        tcp_strap_t lv[3] = '{STRAP_HIGH, STRAP_FLOAT, STRAP_LOW};
        tcp_role_t  rl[3] = '{ROLE_SRC, ROLE_DRP, ROLE_SNK};
        logic [7:0] ad[3] = '{8'h62, 8'h00, 8'h42};
        for (int i = 0; i < 3; i++) begin
            t_en(lv[i], lv[i], i);
            chk("port_role", port_role, rl[i]);
            chk("i2c_mode", i2c_mode, ad[i] != 8'h00);
            chk("i2c_addr", i2c_addr, ad[i]);
            chk("dbg_oe", role_strap_dbg_oe, 1'b1);
            role_strap_level = lv[(i + 1) % 3];
            addr_strap_level = lv[(i + 1) % 3];
            step(4);
            chk("held_role", port_role, rl[i]);
            chk("held_addr", i2c_addr, ad[i]);
        end
        $display("straps done");
    endtask : t_straps

    // The shared pin follows the request in one mode and audio in the other.
    task automatic t_irq(input logic m);
        for (int k = 0; k < 2; k++) begin
            audio_det = k[0];
            irq_req = !k[0];
            step(1);
            chk("irq_oe", irq_or_audio_flag_pin_oe, m ? !k[0] : k[0]);
        end
        audio_det = 1'b0;
        irq_req = 1'b0;
        $display("irq pin done");
    endtask : t_irq

    // The serial slave drives and hears both shared lines.
    task automatic t_i2c;
        for (int k = 0; k < 2; k++) begin
            i2c_sda_pull = !k[0];
            i2c_scl_pull = k[0];
            step(2);
            chk("sda_oe", sda_oe, !k[0]);
            chk("scl_oe", scl_oe, k[0]);
            chk("sda_rx", i2c_sda_rx, k[0]);
            chk("scl_rx", i2c_scl_rx, !k[0]);
        end
        i2c_sda_pull = 1'b0;
        i2c_scl_pull = 1'b0;
        $display("serial pins done");
    endtask : t_i2c

    // Rows: src, present, flip, both lines, Ra, orientation, debug flag.
    task automatic t_orient;
        logic [7:0] c;
        logic [7:0] tab[9] = '{8'h00, 8'h64, 8'h42, 8'h53, 8'h75,
                               8'hEC, 8'hCA, 8'hF5, 8'h80};
        for (int i = 0; i < 9; i++) begin
            c = tab[i];
            attached_src = c[7] && c[6];
            attached_snk = !c[7] && c[6];
            p_src = !c[7];
            p_on = c[6];
            dbg_cc2_sel = c[5];
            p_both = c[4];
            p_ra = c[3];
            step(1);
            chk("flip_bits", flip_state_bits, c[2:1]);
            chk("flip_pin", addr_strap_flip_pin_out, c[2]);
            chk("dbg_flag", debug_test_partner, c[0]);
            chk("dbg_pin", role_strap_dbg_out, !c[0]);
            chk("role_oe", attached_role_out_oe, attached_src);
        end
        $display("orientation done");
    endtask : t_orient

    // Sink drives the current pins; as source the partner sets them.
    task automatic t_cur;
        tcp_cur_t   lv[3] = '{CUR_DEFAULT, CUR_1A5, CUR_3A0};
        logic [1:0] pat[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
        p_on = 1'b0;
        attached_src = 1'b0;
        attached_snk = 1'b1;
        for (int i = 0; i < 3; i++) begin
            snk_cur_level = lv[i];
            step(1);
            chk("cur_a_oe", sda_oe, lv[i] != CUR_DEFAULT);
            chk("cur_b_oe", scl_oe, lv[i] == CUR_3A0);
        end
        attached_snk = 1'b0;
        attached_src = 1'b1;
        p_drv = 1'b1;
        for (int i = 0; i < 4; i++) begin
            p_pat = pat[i];
            step(2);
            chk("adv_cur", adv_cur_level, lv[i < 3 ? i : 2]);
            chk("adv_rsv", adv_cur_reserved, i == 3);
            chk("src_a_oe", sda_oe, 1'b0);
        end
        p_drv = 1'b0;
        attached_src = 1'b0;
        $display("current pins done");
    endtask : t_cur

    // Main sequence.
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_straps();
        t_irq(1'b1);
        t_i2c();
        t_en(STRAP_FLOAT, STRAP_FLOAT, 1);
        t_irq(1'b0);
        t_orient();
        t_cur();
        wrap_up();
    end
endmodule : typec_pin_mode_status_outputs_tb

`default_nettype wire
